// >>> pkg/vec_irq_pkg.sv
// Shared constants and types for the vectored interrupt acknowledge link
package vec_irq_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // Vector register value after reset
  localparam logic [7:0] VECTOR_RST = 8'h0f;
  // Restart opcode base (C7) and step between opcodes
  localparam logic [7:0] RESTART_BASE = 8'hc7;
  localparam logic [7:0] RESTART_STEP = 8'h08;
  // Fixed service address for fixed-address mode
  localparam logic [15:0] FIXED_ADDR = 16'h0038;
  // Processor interrupt handling modes
  typedef enum logic [1:0]
  {
    RESTART_OPCODE_IRQ_MODE = 2'h0,
    FIXED_ADDRESS_IRQ_MODE = 2'h1,
    PERIPHERAL_VECTOR_IRQ_MODE = 2'h2
  } irq_mode_e;
  // Restart opcode to call target (C7->0000 ... FF->0038)
  function automatic logic [15:0] restart_target(input logic [7:0] op);
    restart_target = {10'h000, op[5:3], 3'h0};
  endfunction
  // Service address from page byte and vector, bit 0 forced zero
  function automatic logic [15:0] vector_target(input logic [7:0] page, input logic [7:0] vec);
    vector_target = {page, vec[7:1], 1'b0};
  endfunction
endpackage

// >>> pkg/vec_irq_if.sv
// Interface joining the peripheral and processor ends of the link
`timescale 1ns/1ps
interface vec_irq_if;
  logic irq_out_n;
  logic ack_in_n;
  logic rd_n;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic chain_enable_in;
  logic chain_enable_out;
  // Bus value seen by processor; floats high when nobody drives
  logic [7:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev : 8'hff;
  modport dev (output irq_out_n, input ack_in_n, input rd_n, output data_dev,
               output data_dev_oe, input chain_enable_in, output chain_enable_out);
  modport host (input irq_out_n, output ack_in_n, output rd_n, input data_bus);
endinterface

// >>> src/vec_irq_dev.sv
// Peripheral end: request, daisy chain and vector on acknowledge
`timescale 1ns/1ps
// Contract
// - Drive request low on enabled pending interrupt
// - Acknowledge marks next bus cycle as acknowledge
// - Chained mode: vector onto data on acknowledge
// - Processor builds page, vector 7:1, zero
// - Processor treats vector bit 0 as zero
// - Chain enable low blocks every request in chained mode; non-chained ignores it
// - Processor finishes instruction, acknowledges, reads vector
// - Restart opcodes C7..FF call 0000..0038
// - Fixed-address mode gives no acknowledge
// - Enable out high: enable in, no request
// - Enable out stays low until clear command
// - Reset gives non-chained; command enters chained
module vec_irq_dev
  import vec_irq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  vec_irq_if.dev link,
  input wire logic [7:0] pending_i,
  input wire logic [7:0] mask_i,
  input wire logic [7:0] vector_wr_data_i,
  input wire logic vector_wr_i,
  input wire logic set_chained_cmd_i,
  input wire logic clear_in_service_cmd_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rd_data_i,
  output logic chained_o,
  output logic in_service_o
);
  // Mode group
  logic chained_r;
  logic chained_nxt;
  // Vector register group
  logic [7:0] vector_register_r;
  logic [7:0] vector_register_nxt;
  // Acknowledge and service group
  logic ack_pend_r;
  logic ack_pend_nxt;
  logic in_service_r;
  logic in_service_nxt;
  // Request and daisy-chain group
  logic irq_r;
  logic irq_nxt;
  logic ceo_r;
  logic ceo_nxt;
  // Data bus group
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic oe_r;
  logic oe_nxt;
  // Conditions shared by several groups
  logic want;
  logic ack_take;
  logic ack_done;

  // Acknowledge honoured only in chained mode, once per service
  function automatic logic take_ack(input logic chained, input logic ack_n,
                                    input logic armed, input logic busy);
    take_ack = chained && !ack_n && !armed && !busy;
  endfunction

  assign want = |(pending_i & mask_i);
  assign ack_take = take_ack(chained_r, link.ack_in_n, ack_pend_r, in_service_r);
  // Acknowledge cycle ends with the processor's read strobe
  assign ack_done = ack_pend_r && !link.rd_n;

  // Mode next value
  always_comb
  begin
    chained_nxt = chained_r;
    if (set_chained_cmd_i)
      chained_nxt = 1'b1;
  end

  // Mode register; reset gives non-chained
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      chained_r <= 1'b0;
    else
      chained_r <= chained_nxt;
  end

  // Vector register next value
  always_comb
  begin
    vector_register_nxt = vector_register_r;
    if (vector_wr_i)
      vector_register_nxt = vector_wr_data_i;
  end

  // Vector register storage
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      vector_register_r <= VECTOR_RST;
    else
      vector_register_r <= vector_register_nxt;
  end

  // Acknowledge and service next values
  always_comb
  begin
    in_service_nxt = in_service_r;
    // armed for the one cycle after acknowledge
    ack_pend_nxt = ack_take;
    // service latch released only by command
    if (clear_in_service_cmd_i)
      in_service_nxt = 1'b0;
    // Vector read starts service; wins over a clear
    if (ack_done)
      in_service_nxt = 1'b1;
  end

  // Acknowledge and service registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_pend_r <= 1'b0;
      in_service_r <= 1'b0;
    end
    else
    begin
      ack_pend_r <= ack_pend_nxt;
      in_service_r <= in_service_nxt;
    end
  end

  // Request and enable-out next values
  always_comb
  begin
    // in chained mode, chain enable low gates the request
    if (chained_r)
      irq_nxt = want && link.chain_enable_in && !in_service_nxt;
    else
      irq_nxt = want;
    ceo_nxt = chained_r && link.chain_enable_in && !irq_nxt && !in_service_nxt
              && !ack_pend_nxt;
  end

  // Request and enable-out registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_r <= 1'b0;
      ceo_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      ceo_r <= ceo_nxt;
    end
  end

  // Data bus next values
  always_comb
  begin
    dout_nxt = dout_r;
    oe_nxt = 1'b0;
    // vector onto the bus in the cycle after acknowledge
    if (ack_take)
    begin
      dout_nxt = vector_register_r;
      oe_nxt = 1'b1;
    end
    else if (reg_rd_i)
    begin
      dout_nxt = reg_rd_data_i;
      oe_nxt = 1'b1;
    end
  end

  // Data bus registers; released after one cycle
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else
    begin
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Link pins
  assign link.irq_out_n = !irq_r;
  assign link.chain_enable_out = ceo_r;
  assign link.data_dev = dout_r;
  assign link.data_dev_oe = oe_r;
  // Status outputs
  assign chained_o = chained_r;
  assign in_service_o = in_service_r;
endmodule

// >>> src/vec_irq_host.sv
// Processor end: samples request, acknowledges, forms service address
`timescale 1ns/1ps
module vec_irq_host
  import vec_irq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  vec_irq_if.host link,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] page_i,
  input wire logic insn_done_i,
  output logic [15:0] service_addr_o,
  output logic service_o
);
  typedef enum logic [3:0]
  {
    IDLE = 4'h1,
    WAIT_INSN = 4'h2,
    ACK = 4'h4,
    READ = 4'h8
  } st_e;
  st_e st_r, st_nxt;
  logic ack_n_r, ack_n_nxt;
  logic rd_n_r, rd_n_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic srv_r, srv_nxt;

  // Sequencer
  always_comb
  begin
    st_nxt = st_r;
    ack_n_nxt = 1'b1;
    rd_n_nxt = 1'b1;
    addr_nxt = addr_r;
    srv_nxt = 1'b0;
    unique case (st_r)
      IDLE:
        if (!link.irq_out_n)
          st_nxt = WAIT_INSN;
      WAIT_INSN:
        // Request withdrawn before the instruction ended
        if (link.irq_out_n)
          st_nxt = IDLE;
        else if (insn_done_i)
        begin
          // fixed mode branches with no acknowledge
          if (mode_i == FIXED_ADDRESS_IRQ_MODE)
          begin
            addr_nxt = FIXED_ADDR;
            srv_nxt = 1'b1;
            st_nxt = IDLE;
          end
          else
          begin
            ack_n_nxt = 1'b0;
            st_nxt = ACK;
          end
        end
      ACK:
      begin
        rd_n_nxt = 1'b0;
        st_nxt = READ;
      end
      READ:
      begin
        if (mode_i == RESTART_OPCODE_IRQ_MODE)
          addr_nxt = restart_target(link.data_bus);
        // page byte and vector bits 7:1
        // vector bit 0 taken as zero
        else
          addr_nxt = vector_target(page_i, link.data_bus);
        srv_nxt = 1'b1;
        st_nxt = IDLE;
      end
      default:
        st_nxt = IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= IDLE;
      ack_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      addr_r <= 16'h0000;
      srv_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ack_n_r <= ack_n_nxt;
      rd_n_r <= rd_n_nxt;
      addr_r <= addr_nxt;
      srv_r <= srv_nxt;
    end
  end

  assign link.ack_in_n = ack_n_r;
  assign link.rd_n = rd_n_r;
  assign service_addr_o = addr_r;
  assign service_o = srv_r;
endmodule

// >>> dv/vec_irq_properties.sv
// Checks on the link signals
`timescale 1ns/1ps
module vec_irq_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic irq_out_n,
  input wire logic ack_in_n,
  input wire logic rd_n,
  input wire logic data_dev_oe,
  input wire logic chain_enable_in,
  input wire logic chain_enable_out
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Acknowledge, then read with the vector on the bus in the same cycle
  sequence served_s;
    !ack_in_n ##1 (!rd_n && data_dev_oe);
  endsequence
  ack_rd_a: assert property ($fell(ack_in_n) |=> ack_in_n && !rd_n)
    else $error("no read after ack");
  rd_pulse_a: assert property (!rd_n |=> rd_n)
    else $error("read too long");
  oe_pulse_a: assert property (data_dev_oe |=> !data_dev_oe)
    else $error("bus held");
  eo_quiet_a: assert property (chain_enable_out |-> irq_out_n)
    else $error("enable out while requesting");
  eo_follow_a: assert property (chain_enable_out |-> $past(chain_enable_in))
    else $error("enable out without in");
  chain_block_a: assert property (chain_enable_out && !chain_enable_in |=> irq_out_n)
    else $error("request while blocked");
  held_low_a: assert property (served_s |=> !chain_enable_out [*3])
    else $error("enable out rose in service");
  reset_plain_a: assert property ($fell(rst_i) |-> !chain_enable_out [*2])
    else $error("chained after reset");
endmodule

// >>> dv/vectored_interrupt_ack_tb.sv
// Bench for both link ends
`timescale 1ns/1ps
module vectored_interrupt_ack_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] pend = 8'h00, msk = 8'h01, vwd = 8'ha5, rrdd = 8'h3c, page = 8'h12;
  logic vwr = 1'b0, setc = 1'b0, clr = 1'b0, rrd = 1'b0, insn = 1'b0;
  logic [1:0] mode = 2'h0;
  logic chained, insv, svc;
  logic [15:0] saddr;
  int num_errors = 0, n_compared = 0, cyc = 0;
  vec_irq_if lk();
  initial lk.chain_enable_in = 1'b0;
  vec_irq_dev u_vec_irq_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lk.dev),
    .pending_i(pend), .mask_i(msk), .vector_wr_data_i(vwd), .vector_wr_i(vwr),
    .set_chained_cmd_i(setc), .clear_in_service_cmd_i(clr), .reg_rd_i(rrd),
    .reg_rd_data_i(rrdd), .chained_o(chained), .in_service_o(insv));
  vec_irq_host u_vec_irq_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(lk.host),
    .mode_i(mode), .page_i(page), .insn_done_i(insn), .service_addr_o(saddr),
    .service_o(svc));
  vec_irq_properties u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .irq_out_n(lk.irq_out_n), .ack_in_n(lk.ack_in_n), .rd_n(lk.rd_n),
    .data_dev_oe(lk.data_dev_oe), .chain_enable_in(lk.chain_enable_in),
    .chain_enable_out(lk.chain_enable_out));
  always #5 clk_sys_i = ~clk_sys_i;
  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    wt(1);
    s = 1'b0;
  endtask
  // One service in mode m; counts acknowledge cycles on the way
  task automatic t_serve(input logic [1:0] m, input logic [15:0] e);
    int acks;
    acks = 0;
    mode = m;
    insn = 1'b1;
    for (int i = 0; i < 20 && svc !== 1'b1; i++)
    begin
      if (lk.ack_in_n === 1'b0)
        acks++;
      wt(1);
    end
    insn = 1'b0;
    chk(16'(svc), 16'h0001);
    chk(saddr, e);
    chk(16'(acks), (m == 2'h1) ? 16'h0000 : 16'h0001);
    wt(6);
  endtask
  task automatic t_modes;
    chk(16'(chained), 16'h0000);
    // Masked condition raises nothing
    pend = 8'h02;
    wt(2);
    chk(16'(lk.irq_out_n), 16'h0001);
    pend = 8'h01;
    wt(2);
    chk(16'(lk.irq_out_n), 16'h0000);
    t_serve(2'h0, 16'h0038);
    t_serve(2'h2, {page, 8'hfe});
    t_serve(2'h1, 16'h0038);
    pend = 8'h00;
    wt(2);
  endtask
  task automatic t_read;
    pulse(rrd);
    chk(16'(lk.data_bus), 16'(rrdd));
    wt(1);
    chk(16'(lk.data_dev_oe), 16'h0000);
  endtask
  task automatic t_chain;
    pulse(vwr);
    pulse(setc);
    lk.chain_enable_in = 1'b1;
    wt(3);
    chk(16'(chained), 16'h0001);
    chk(16'(lk.chain_enable_out), 16'h0001);
    lk.chain_enable_in = 1'b0;
    pend = 8'h01;
    wt(3);
    chk(16'(lk.irq_out_n), 16'h0001);
    lk.chain_enable_in = 1'b1;
    wt(2);
    chk(16'(lk.chain_enable_out), 16'h0000);
    mode = 2'h2;
    insn = 1'b1;
    for (int i = 0; i < 20 && lk.data_dev_oe !== 1'b1; i++)
      wt(1);
    chk(16'(lk.data_bus), 16'(vwd));
    insn = 1'b0;
    pend = 8'h00;
    wt(1);
    chk(saddr, {page, vwd[7:1], 1'b0});
    wt(3);
    chk(16'(insv), 16'h0001);
    chk(16'(lk.chain_enable_out), 16'h0000);
    pulse(clr);
    wt(2);
    chk(16'(lk.chain_enable_out), 16'h0001);
    // Second chained service: restart opcode taken from the vector
    vwd = 8'he7;
    pulse(vwr);
    pend = 8'h01;
    t_serve(2'h0, 16'h0020);
    pend = 8'h00;
    pulse(clr);
    wt(2);
  endtask
  task automatic finish_test;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    wt(6);
    rst_i = 1'b0;
    wt(2);
    t_modes();
    t_read();
    t_chain();
    finish_test();
  end
endmodule
